// [fan_tach_monitor.sv]
// two-channel fan tachometer monitor with an AXI4-Lite register slave and an interrupt output
// assumes tachometer and oscillator pins are slow and asynchronous; one 125 MHz clock drives all logic
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps

// Behaviour
// - counters are clocked by the 32.765kHz reference over the channel divisor; divisor 1 gives the raw one
// - 8-bit counter increments only within one tachometer period, max 255
// - config bit picks external oscillator pin or internal clock from system clock
// - count restarts on each tachometer rising edge and on preload write
// - a restart loads the channel preload value, not zero
// - counter saturates at 0xFF until the next restart
// - both count msbs set raises wake and/or SMI, each with own enable
// - per-channel divisor 1, 2, 4 or 8, default 2
// - count rate is reference over divisor, count equals term plus preload
// - two channels with separate preloads work independently
// - divisor fields sit at fan control bits 7:6 and 5:4
module fan_tach_monitor
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic EXT_SLOW_OSC_PIN,
	input wire logic TACH_INPUT_ONE,
	input wire logic TACH_INPUT_TWO,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic WAKE_EVENT,
	output logic SMI_EVENT,
	output logic IRQ
);

	function automatic logic tick_due(input logic [2:0] pre, input logic [1:0] code);
		return code == 2'h0 || (code == 2'h1 && pre[0]) || (code == 2'h2 && &pre[1:0]) || (code == 2'h3 && &pre);
	endfunction
	function automatic logic [7:0] next_count(input logic [7:0] cnt, input logic inc);
		return (inc && cnt != fan_tach_pkg::COUNT_MAX) ? cnt + 8'h01 : cnt;
	endfunction
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;
	// registers
	logic [7:0] fan_ctrl_reg;
	logic [7:0] preload_one_reg;
	logic [7:0] preload_two_reg;
	logic osc_present_select;
	logic [1:0] wake_en_reg;
	logic [1:0] smi_en_reg;
	logic [3:0] status_reg;
	logic [3:0] mask_reg;
	// write channel
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	logic wr_bad;

	assign S_AXI_AWREADY = !aw_held_reg && !S_AXI_BVALID;
	assign S_AXI_WREADY = !w_held_reg && !S_AXI_BVALID;
	assign do_write = aw_held_reg && w_held_reg && !S_AXI_BVALID;
	assign wr_bad = aw_addr_reg > fan_tach_pkg::OFF_COUNT || aw_addr_reg[1:0] != 2'h0;

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= fan_tach_pkg::RESP_OKAY;
		end
		else
		begin
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (do_write)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_bad ? fan_tach_pkg::RESP_SLVERR : fan_tach_pkg::RESP_OKAY;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	logic wr_lane0;
	logic preload_one_wr;
	logic preload_two_wr;
	assign wr_lane0 = do_write && w_strb_reg[0];
	assign preload_one_wr = wr_lane0 && aw_addr_reg == fan_tach_pkg::OFF_PRELOAD_ONE;
	assign preload_two_wr = wr_lane0 && aw_addr_reg == fan_tach_pkg::OFF_PRELOAD_TWO;

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fan_ctrl_reg <= fan_tach_pkg::FAN_CTRL_RESET;
			preload_one_reg <= fan_tach_pkg::PRELOAD_RESET;
			preload_two_reg <= fan_tach_pkg::PRELOAD_RESET;
			osc_present_select <= 1'b0;
			wake_en_reg <= 2'h0;
			smi_en_reg <= 2'h0;
			mask_reg <= 4'h0;
		end
		else if (wr_lane0)
		begin
			case (aw_addr_reg)
				fan_tach_pkg::OFF_FAN_CTRL: fan_ctrl_reg <= {w_data_reg[7:4], 4'h0};
				fan_tach_pkg::OFF_PRELOAD_ONE: preload_one_reg <= w_data_reg[7:0];
				fan_tach_pkg::OFF_PRELOAD_TWO: preload_two_reg <= w_data_reg[7:0];
				fan_tach_pkg::OFF_CLK_CFG: osc_present_select <= w_data_reg[0];
				fan_tach_pkg::OFF_WAKE_EN: wake_en_reg <= w_data_reg[1:0];
				fan_tach_pkg::OFF_SMI_EN: smi_en_reg <= w_data_reg[1:0];
				fan_tach_pkg::OFF_MASK: mask_reg <= w_data_reg[3:0];
				default: ;
			endcase
		end
	end

	// slow reference: external pin synchronised, or internal divider
	logic osc_meta_reg;
	logic osc_sync_reg;
	logic osc_prev_reg;
	logic [15:0] int_div_reg;
	logic int_tick;
	logic ref_tick;

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			osc_prev_reg <= 1'b0;
			int_div_reg <= 16'h0000;
		end
		else
		begin
			osc_meta_reg <= EXT_SLOW_OSC_PIN;
			osc_sync_reg <= osc_meta_reg;
			osc_prev_reg <= osc_sync_reg;
			if (int_tick)
				int_div_reg <= 16'h0000;
			else
				int_div_reg <= int_div_reg + 16'h0001;
		end
	end
	assign int_tick = int_div_reg == 16'(fan_tach_pkg::INT_REF_CYCLES - 1);
	assign ref_tick = osc_present_select ? (osc_sync_reg && !osc_prev_reg) : int_tick;

	// shared prescaler; each channel takes its own tap so rates stay independent
	logic [2:0] pre_reg;
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
			pre_reg <= 3'h0;
		else if (ref_tick)
			pre_reg <= pre_reg + 3'h1;
	end

	fan_tach_pkg::chan_s ch_one_reg;
	fan_tach_pkg::chan_s ch_two_reg;
	logic tach_meta_one_reg;
	logic tach_meta_two_reg;
	logic inc_one;
	logic inc_two;
	logic rise_one;
	logic rise_two;
	// divided rate is reference ticks gated by the selected prescaler tap
	assign inc_one = ref_tick && tick_due(pre_reg, fan_ctrl_reg[fan_tach_pkg::DIV_ONE_LSB +: 2]);
	assign inc_two = ref_tick && tick_due(pre_reg, fan_ctrl_reg[fan_tach_pkg::DIV_TWO_LSB +: 2]);
	assign rise_one = ch_one_reg.tach_sync && !ch_one_reg.tach_prev;
	assign rise_two = ch_two_reg.tach_sync && !ch_two_reg.tach_prev;

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tach_meta_one_reg <= 1'b0;
			tach_meta_two_reg <= 1'b0;
			ch_one_reg <= '0;
			ch_two_reg <= '0;
		end
		else
		begin
			tach_meta_one_reg <= TACH_INPUT_ONE;
			tach_meta_two_reg <= TACH_INPUT_TWO;
			ch_one_reg.tach_sync <= tach_meta_one_reg;
			ch_two_reg.tach_sync <= tach_meta_two_reg;
			ch_one_reg.tach_prev <= ch_one_reg.tach_sync;
			ch_two_reg.tach_prev <= ch_two_reg.tach_sync;
			// counting runs between successive rising edges, i.e. one tachometer period
			if (rise_one || preload_one_wr)
				ch_one_reg.count <= preload_one_wr ? w_data_reg[7:0] : preload_one_reg;
			else
				ch_one_reg.count <= next_count(ch_one_reg.count, inc_one);
			if (rise_two || preload_two_wr)
				ch_two_reg.count <= preload_two_wr ? w_data_reg[7:0] : preload_two_reg;
			else
				ch_two_reg.count <= next_count(ch_two_reg.count, inc_two);
		end
	end

	// threshold events: one pulse as the count crosses into the top quarter
	logic [1:0] hit_reg;
	logic [1:0] hit;
	logic [1:0] hit_rise;
	assign hit[0] = ch_one_reg.count[7:6] == fan_tach_pkg::THRESH_MSBS;
	assign hit[1] = ch_two_reg.count[7:6] == fan_tach_pkg::THRESH_MSBS;
	assign hit_rise = hit & ~hit_reg;
	logic [3:0] status_set;
	logic [3:0] status_clr;
	assign status_set = {hit_rise & smi_en_reg, hit_rise & wake_en_reg};
	assign status_clr = (wr_lane0 && aw_addr_reg == fan_tach_pkg::OFF_STATUS) ? w_data_reg[3:0] : 4'h0;

	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hit_reg <= 2'h0;
			status_reg <= 4'h0;
		end
		else
		begin
			hit_reg <= hit;
			// set beats a simultaneous write-one-to-clear
			status_reg <= (status_reg & ~status_clr) | status_set;
		end
	end

	// wake and SMI outputs follow the comparator registered one cycle late, gated by the enables; IRQ follows status gated by the mask
	assign WAKE_EVENT = |(hit_reg & wake_en_reg);
	assign SMI_EVENT = |(hit_reg & smi_en_reg);
	assign IRQ = |(status_reg & mask_reg);

	// read channel
	fan_tach_pkg::rd_state_e rd_state_reg;
	logic [7:0] ar_addr_reg;
	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (ar_addr_reg)
			fan_tach_pkg::OFF_FAN_CTRL: rd_word[7:0] = fan_ctrl_reg;
			fan_tach_pkg::OFF_PRELOAD_ONE: rd_word[7:0] = preload_one_reg;
			fan_tach_pkg::OFF_PRELOAD_TWO: rd_word[7:0] = preload_two_reg;
			fan_tach_pkg::OFF_CLK_CFG: rd_word[0] = osc_present_select;
			fan_tach_pkg::OFF_WAKE_EN: rd_word[1:0] = wake_en_reg;
			fan_tach_pkg::OFF_SMI_EN: rd_word[1:0] = smi_en_reg;
			fan_tach_pkg::OFF_STATUS: rd_word[3:0] = status_reg;
			fan_tach_pkg::OFF_MASK: rd_word[3:0] = mask_reg;
			fan_tach_pkg::OFF_COUNT: rd_word[15:0] = {ch_two_reg.count, ch_one_reg.count};
			default: rd_word = 32'h0000_0000;
		endcase
	end
	assign S_AXI_ARREADY = rd_state_reg == fan_tach_pkg::RD_IDLE;
	assign S_AXI_RVALID = rd_state_reg == fan_tach_pkg::RD_RESP;
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_state_reg <= fan_tach_pkg::RD_IDLE;
			ar_addr_reg <= 8'h00;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= fan_tach_pkg::RESP_OKAY;
		end
		else
		begin
			case (rd_state_reg)
				fan_tach_pkg::RD_IDLE:
					if (S_AXI_ARVALID)
					begin
						ar_addr_reg <= S_AXI_ARADDR;
						rd_state_reg <= fan_tach_pkg::RD_FETCH;
					end
				fan_tach_pkg::RD_FETCH:
				begin
					S_AXI_RDATA <= rd_word;
					S_AXI_RRESP <= (ar_addr_reg > fan_tach_pkg::OFF_COUNT || ar_addr_reg[1:0] != 2'h0)
						? fan_tach_pkg::RESP_SLVERR : fan_tach_pkg::RESP_OKAY;
					rd_state_reg <= fan_tach_pkg::RD_RESP;
				end
				fan_tach_pkg::RD_RESP:
					if (S_AXI_RREADY)
						rd_state_reg <= fan_tach_pkg::RD_IDLE;
				default: rd_state_reg <= fan_tach_pkg::RD_IDLE;
			endcase
		end
	end

endmodule

// [fan_tach_pkg.sv]
// package for the two-channel fan tachometer monitor: register map, fields, reset values, timing
// assumes a 125 MHz system clock and an AXI4-Lite master with 32-bit data
package fan_tach_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_FAN_CTRL = 8'h00;
	localparam logic [7:0] OFF_PRELOAD_ONE = 8'h04;
	localparam logic [7:0] OFF_PRELOAD_TWO = 8'h08;
	localparam logic [7:0] OFF_CLK_CFG = 8'h0C;
	localparam logic [7:0] OFF_WAKE_EN = 8'h10;
	localparam logic [7:0] OFF_SMI_EN = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_MASK = 8'h1C;
	localparam logic [7:0] OFF_COUNT = 8'h20;

	// fan control fields
	localparam int DIV_ONE_LSB = 6;
	localparam int DIV_TWO_LSB = 4;
	localparam logic [7:0] FAN_CTRL_RESET = 8'h50;
	localparam logic [7:0] PRELOAD_RESET = 8'h00;

	// status bit positions: wake one, wake two, smi one, smi two
	localparam int ST_WAKE_ONE = 0;
	localparam int ST_WAKE_TWO = 1;
	localparam int ST_SMI_ONE = 2;
	localparam int ST_SMI_TWO = 3;

	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [1:0] THRESH_MSBS = 2'h3;

	// internal slow reference from the system clock
	localparam int SYS_CLK_HZ = 125000000;
	localparam int INT_REF_HZ = 32765;
	localparam int INT_REF_CYCLES = SYS_CLK_HZ / INT_REF_HZ;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		RD_IDLE = 3'h1,
		RD_FETCH = 3'h2,
		RD_RESP = 3'h4
	} rd_state_e;

	typedef struct packed
	{
		logic [7:0] count;
		logic       tach_sync;
		logic       tach_prev;
	} chan_s;

endpackage

// [fan_tach_monitor_assertions.sv]
// register bus handshake checks for the fan tachometer monitor
// assumes it is bound to fan_tach_monitor and sees only its ports
`timescale 1ns/1ps
module fan_tach_monitor_chk
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic [1:0] S_AXI_RRESP,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	property p_bhold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_wlat; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> !S_AXI_BVALID ##1 S_AXI_BVALID; endproperty
	a_wlat: assert property (p_wlat) else $error("write response late");
	property p_awblk; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
	a_awblk: assert property (p_awblk) else $error("write taken while response pending");
	property p_rlat; S_AXI_ARVALID && S_AXI_ARREADY |=> !S_AXI_RVALID ##1 S_AXI_RVALID; endproperty
	a_rlat: assert property (p_rlat) else $error("read data not two cycles after address");
	property p_arblk; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
	a_arblk: assert property (p_arblk) else $error("read taken while data pending");
	property p_rhold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP); endproperty
	a_rhold: assert property (p_rhold) else $error("read data changed before accepted");
	property p_rerr; S_AXI_RVALID && S_AXI_RRESP == fan_tach_pkg::RESP_SLVERR |-> S_AXI_RDATA == 32'h0; endproperty
	a_rerr: assert property (p_rerr) else $error("refused read returned data");
	property p_rhigh; S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0; endproperty
	a_rhigh: assert property (p_rhigh) else $error("upper read bits not zero");
endmodule
bind fan_tach_monitor fan_tach_monitor_chk u_chk(.CLK_SYS(CLK_SYS), .RST_B(RST_B),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// [fan_tach_model.sv]
// fan tachometer output: square wave while spinning, held low once stopped
// assumes the bench holds half steady while spin is high
`timescale 1ns/1ps
module fan_tach_model
(
	input wire logic clk,
	input wire logic spin,
	input wire logic [7:0] half,
	output logic tach
);
	logic [7:0] cnt;
	initial tach = 1'b0;
	initial cnt = 8'h0;
	always @(posedge clk)
	begin
		if (!spin)
		begin
			tach <= 1'b0;
			cnt <= 8'h0;
		end
		else if (cnt >= half)
		begin
			tach <= !tach;
			cnt <= 8'h0;
		end
		else
			cnt <= cnt + 8'h1;
	end
endmodule

// [fan_tach_monitor_bench.sv]
// self-checking bench: register bus master, slow oscillator pin and two fan models
// selects the external oscillator so counts follow the bench's own ticks, then switches to the internal reference for the last check
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, e); end end
module fan_tach_monitor_bench;
	logic clk = 0, rst_b = 0, osc = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, sp1 = 0, sp2 = 0;
	logic t1, t2, awrdy, wrdy, bvalid, arrdy, rvalid, wake, smi, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] wdata = 0, rdata, d;
	logic [7:0] awaddr = 0, araddr = 0, h2 = 8'h1, p1, p2;
	int n_fail = 0, tests_run = 0, c;
	always #4 clk = ~clk;
	fan_tach_model u_f1(.clk(clk), .spin(sp1), .half(8'h3), .tach(t1));
	fan_tach_model u_f2(.clk(clk), .spin(sp2), .half(h2), .tach(t2));
	fan_tach_monitor u_dut(.CLK_SYS(clk), .RST_B(rst_b), .EXT_SLOW_OSC_PIN(osc), .TACH_INPUT_ONE(t1),
		.TACH_INPUT_TWO(t2), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
		.S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .WAKE_EVENT(wake), .SMI_EVENT(smi), .IRQ(irq));
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task stuck;
		n_fail++;
		$display("ERROR %0t bus timeout", $time);
		tally_and_finish;
	endtask
	function automatic logic [7:0] sat(input logic [7:0] p, input int n);
		return (p + n > 255) ? 8'hFF : 8'(p + n);
	endfunction
	// the ready side is sometimes raised late so held responses get exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] q);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= x;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'($urandom % 2);
		for (i = 0; i < 64; i++)
		begin
			@(posedge clk);
			if (awv && awrdy) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (bvalid && bready) break;
			if (bvalid) bready <= 1'b1;
		end
		q = bresp;
		bready <= 1'b0;
		if (i == 64) stuck;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] q);
		int i;
		@(posedge clk);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'($urandom % 2);
		for (i = 0; i < 64; i++)
		begin
			@(posedge clk);
			if (arv && arrdy) arv <= 1'b0;
			if (rvalid && rready) break;
			if (rvalid) rready <= 1'b1;
		end
		x = rdata;
		q = rresp;
		rready <= 1'b0;
		if (i == 64) stuck;
	endtask
	task automatic wok(input logic [7:0] a, input logic [31:0] x);
		logic [1:0] q;
		wr(a, x, q);
		`CHK(q, fan_tach_pkg::RESP_OKAY)
	endtask
	task automatic chkr(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		logic [1:0] q;
		rd(a, x, q);
		`CHK(q, fan_tach_pkg::RESP_OKAY)
		`CHK(x, e)
	endtask
	task automatic ticks(input int n);
		repeat (n)
		begin
			osc <= 1'b1;
			repeat (4) @(posedge clk);
			osc <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	initial
	begin
		void'($urandom(32'hC7E9));
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		chkr(fan_tach_pkg::OFF_FAN_CTRL, 32'h50);
		chkr(fan_tach_pkg::OFF_CLK_CFG, 32'h0);
		rd(8'h24, d, r);
		`CHK({r, d}, {fan_tach_pkg::RESP_SLVERR, 32'h0})
		wr(8'h24, 32'hFF, r);
		`CHK(r, fan_tach_pkg::RESP_SLVERR)
		wok(fan_tach_pkg::OFF_CLK_CFG, 32'h1);
		chkr(fan_tach_pkg::OFF_CLK_CFG, 32'h1);
		for (c = 0; c < 4; c++)
		begin
			p1 = (c == 0) ? 8'hFC : 8'($urandom % 256);
			p2 = 8'($urandom % 256);
			h2 <= 8'(c * 2);
			wok(fan_tach_pkg::OFF_FAN_CTRL, {24'h0, 2'(c), 2'(c), 4'h0});
			chkr(fan_tach_pkg::OFF_FAN_CTRL, {24'h0, 2'(c), 2'(c), 4'h0});
			wok(fan_tach_pkg::OFF_PRELOAD_ONE, {24'h0, p1});
			wok(fan_tach_pkg::OFF_PRELOAD_TWO, {24'h0, p2});
			chkr(fan_tach_pkg::OFF_COUNT, {16'h0, p2, p1});
			ticks(8 << c);
			chkr(fan_tach_pkg::OFF_COUNT, {16'h0, sat(p2, 8), sat(p1, 8)});
			sp2 <= 1'b1;
			repeat (16) @(posedge clk);
			sp2 <= 1'b0;
			repeat (8) @(posedge clk);
			chkr(fan_tach_pkg::OFF_COUNT, {16'h0, p2, sat(p1, 8)});
		end
		wok(fan_tach_pkg::OFF_FAN_CTRL, 32'h50);
		wok(fan_tach_pkg::OFF_WAKE_EN, 32'h1);
		wok(fan_tach_pkg::OFF_SMI_EN, 32'h2);
		wok(fan_tach_pkg::OFF_PRELOAD_ONE, 32'd32);
		wok(fan_tach_pkg::OFF_PRELOAD_TWO, 32'd32);
		ticks(318);
		chkr(fan_tach_pkg::OFF_COUNT, 32'hBFBF);
		`CHK({wake, smi}, 2'b00)
		ticks(2);
		chkr(fan_tach_pkg::OFF_STATUS, 32'h9);
		`CHK({wake, smi, irq}, 3'b110)
		wok(fan_tach_pkg::OFF_MASK, 32'h1);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		wok(fan_tach_pkg::OFF_STATUS, 32'h1);
		chkr(fan_tach_pkg::OFF_STATUS, 32'h8);
		sp1 <= 1'b1;
		repeat (10) @(posedge clk);
		sp1 <= 1'b0;
		repeat (8) @(posedge clk);
		`CHK({wake, smi, irq}, 3'b010)
		wok(fan_tach_pkg::OFF_CLK_CFG, 32'h0);
		wok(fan_tach_pkg::OFF_FAN_CTRL, 32'h0);
		wok(fan_tach_pkg::OFF_PRELOAD_ONE, 32'h0);
		// internal reference: two divider periods hold two or three ticks, depending on its phase
		repeat (2 * fan_tach_pkg::INT_REF_CYCLES) @(posedge clk);
		rd(fan_tach_pkg::OFF_COUNT, d, r);
		`CHK(r, fan_tach_pkg::RESP_OKAY)
		`CHK(d[7:0] == 8'h02 || d[7:0] == 8'h03, 1'b1)
		tally_and_finish;
	end
endmodule
